/* File: csc_regs.vh */
// register indices, field positions, reset values and codes of the channel and sense configuration bank
// Notes on behaviour
// - eight channel setting registers at consecutive indices, channel order, identical layout.
// - bit 7 powers the channel down; zero is normal operation and reset.
// - gain code 000..110 gives 1,2,4,6,8,12,24; 111 undefined; reset 110.
// - bit 3 closes the shared reference switch; zero open, the reset state.
// - selector 000 electrode, 001 shorted, 011 supply, 100 temperature, 101 test.
// - selector 010 routes the bias signal only with the bias measure enable.
// - selector 110 drives positive electrode, 111 drives negative electrode.
// - positive bias sense mask, bit k-1 picks channel k positive input.
// - negative bias sense mask, bit k-1 picks channel k negative input.
// - positive electrode-off mask, bit k-1 enables detection on channel k positive.
// - negative electrode-off mask, bit k-1 enables detection on channel k negative.
// - bias measure enable set routes bias input to selector-010 channels, else open.
// - electrode-off status bit reads zero attached (reset), one detached.
`ifndef CSC_REGS_VH
`define CSC_REGS_VH

// register indices; byte address is four times the index
`define CSC_IDX_BIAS_CTRL 6'h03
`define CSC_IDX_CHAN1 6'h05
`define CSC_IDX_CHAN8 6'h0c
`define CSC_IDX_BIAS_POS 6'h0d
`define CSC_IDX_BIAS_NEG 6'h0e
`define CSC_IDX_EOFF_POS 6'h0f
`define CSC_IDX_EOFF_NEG 6'h10
`define CSC_IDX_EOFF_STAT_POS 6'h12
`define CSC_IDX_EOFF_STAT_NEG 6'h13

// channel settings and bias control fields
`define CSC_POWER_OFF_BIT 7
`define CSC_GAIN_MSB 6
`define CSC_GAIN_LSB 4
`define CSC_SHARED_REF_BIT 3
`define CSC_SEL_MSB 2
`define CSC_SEL_LSB 0
`define CSC_BIAS_MEASURE_ENABLE_BIT 4

// reset values
`define CSC_CHAN_RESET 8'h60
`define CSC_GAIN_RESET 3'h6
`define CSC_MASK_RESET 8'h00
`define CSC_CTRL_RESET 8'h00
`define CSC_STAT_RESET 8'h00

// gain codes
`define CSC_GAIN_UNDEFINED 3'h7

// input selector codes
`define CSC_SEL_ELECTRODE 3'h0
`define CSC_SEL_SHORTED 3'h1
`define CSC_SEL_BIAS_MEASURE_ENABLE 3'h2
`define CSC_SEL_SUPPLY 3'h3
`define CSC_SEL_TEMP 3'h4
`define CSC_SEL_TEST 3'h5
`define CSC_SEL_DRIVE_POS 3'h6
`define CSC_SEL_DRIVE_NEG 3'h7

`endif

/* File: csc_channel_decode.v */
// per-channel decode of one settings byte into registered analog controls
`timescale 1ns/1ps
`include "csc_regs.vh"
module csc_channel_decode (
  input wire clk,
  input wire reset,
  input wire [7:0] settings,
  input wire bias_measure_enable,
  output reg channel_power_off,
  output reg [2:0] gain_code,
  output reg gain_valid,
  output reg shared_reference_switch,
  output reg sel_electrode,
  output reg sel_shorted,
  output reg sel_bias_measure,
  output reg sel_supply_monitor,
  output reg sel_temperature,
  output reg sel_test_signal,
  output reg drive_on_positive_electrode,
  output reg drive_on_negative_electrode
);
  wire [2:0] input_selector = settings[`CSC_SEL_MSB:`CSC_SEL_LSB];

  always @(posedge clk) begin
    if (reset) begin
      channel_power_off <= 1'b0;
      gain_code <= `CSC_GAIN_RESET;
      gain_valid <= 1'b1;
      shared_reference_switch <= 1'b0;
      sel_electrode <= 1'b1;
      sel_shorted <= 1'b0;
      sel_bias_measure <= 1'b0;
      sel_supply_monitor <= 1'b0;
      sel_temperature <= 1'b0;
      sel_test_signal <= 1'b0;
      drive_on_positive_electrode <= 1'b0;
      drive_on_negative_electrode <= 1'b0;
    end else begin
      channel_power_off <= settings[`CSC_POWER_OFF_BIT];
      gain_code <= settings[`CSC_GAIN_MSB:`CSC_GAIN_LSB];
      gain_valid <= settings[`CSC_GAIN_MSB:`CSC_GAIN_LSB] != `CSC_GAIN_UNDEFINED;
      shared_reference_switch <= settings[`CSC_SHARED_REF_BIT];
      sel_electrode <= input_selector == `CSC_SEL_ELECTRODE;
      sel_shorted <= input_selector == `CSC_SEL_SHORTED;
      sel_supply_monitor <= input_selector == `CSC_SEL_SUPPLY;
      sel_temperature <= input_selector == `CSC_SEL_TEMP;
      sel_test_signal <= input_selector == `CSC_SEL_TEST;
      sel_bias_measure <= (input_selector == `CSC_SEL_BIAS_MEASURE_ENABLE) && bias_measure_enable;
      drive_on_positive_electrode <= input_selector == `CSC_SEL_DRIVE_POS;
      drive_on_negative_electrode <= input_selector == `CSC_SEL_DRIVE_NEG;
    end
  end
endmodule // csc_channel_decode

/* File: csc_status_sync.v */
// two-stage synchroniser for the eight comparator outputs of one electrode side
`timescale 1ns/1ps
`include "csc_regs.vh"
module csc_status_sync (
  input wire clk,
  input wire reset,
  input wire [7:0] detached_async,
  output reg [7:0] status
);
  reg [7:0] meta_reg;

  always @(posedge clk) begin
    if (reset) begin
      meta_reg <= `CSC_STAT_RESET;
      status <= `CSC_STAT_RESET;
    end else begin
      meta_reg <= detached_async;
      status <= meta_reg;
    end
  end
endmodule // csc_status_sync

/* File: csc_config_bank.v */
// channel and sense configuration register bank with avalon-mm slave
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "csc_regs.vh"
module csc_config_bank (
  input wire clk,
  input wire reset,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [7:0] electrode_off_pos_detached,
  input wire [7:0] electrode_off_neg_detached,
  output wire [7:0] channel_power_off,
  output wire [23:0] gain_code,
  output wire [7:0] gain_valid,
  output wire [7:0] shared_reference_switch,
  output wire [7:0] sel_electrode,
  output wire [7:0] sel_shorted,
  output wire [7:0] sel_bias_measure,
  output wire [7:0] sel_supply_monitor,
  output wire [7:0] sel_temperature,
  output wire [7:0] sel_test_signal,
  output wire [7:0] drive_on_positive_electrode,
  output wire [7:0] drive_on_negative_electrode,
  output reg [7:0] bias_pos_channel_bit,
  output reg [7:0] bias_neg_channel_bit,
  output reg [7:0] electrode_off_pos_channel_bit,
  output reg [7:0] electrode_off_neg_channel_bit,
  output reg bias_measure_enable
);
  // bus states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] channel_settings_reg [0:7];
  reg [7:0] bias_positive_select_reg;
  reg [7:0] bias_negative_select_reg;
  reg [7:0] electrode_off_positive_select_reg;
  reg [7:0] electrode_off_negative_select_reg;
  reg bias_measure_enable_reg;
  reg [7:0] read_byte_next;
  wire [5:0] index = avs_address[7:2];
  wire request = avs_read | avs_write;
  // a write lands on the edge at which the master sees waitrequest low
  wire commit = (state_reg == ST_DONE) && avs_write && avs_byteenable[0];
  wire [7:0] wdata = avs_writedata[7:0];
  wire [7:0] electrode_off_positive_status;
  wire [7:0] electrode_off_negative_status;

  // bus handshake: one wait cycle, then the answer
  always @* begin
    case (state_reg)
      ST_IDLE: state_next = request ? ST_DONE : ST_IDLE;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      avs_waitrequest <= state_next != ST_DONE;
      if (state_reg == ST_IDLE && avs_read) begin
        avs_readdata <= {24'h000000, read_byte_next};
      end
    end
  end

  // read selection; unmapped indices and reserved bits read zero
  always @* begin
    read_byte_next = 8'h00;
    if (index >= `CSC_IDX_CHAN1 && index <= `CSC_IDX_CHAN8) begin
      read_byte_next = channel_settings_reg[index[2:0] - 3'h5];
    end else begin
      case (index)
        `CSC_IDX_BIAS_CTRL: read_byte_next[`CSC_BIAS_MEASURE_ENABLE_BIT] = bias_measure_enable_reg;
        `CSC_IDX_BIAS_POS: read_byte_next = bias_positive_select_reg;
        `CSC_IDX_BIAS_NEG: read_byte_next = bias_negative_select_reg;
        `CSC_IDX_EOFF_POS: read_byte_next = electrode_off_positive_select_reg;
        `CSC_IDX_EOFF_NEG: read_byte_next = electrode_off_negative_select_reg;
        `CSC_IDX_EOFF_STAT_POS: read_byte_next = electrode_off_positive_status;
        `CSC_IDX_EOFF_STAT_NEG: read_byte_next = electrode_off_negative_status;
        default: read_byte_next = 8'h00;
      endcase
    end
  end

  // channel setting registers and their decoders, one per channel
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_chan
      always @(posedge clk) begin
        if (reset) begin
          channel_settings_reg[k] <= `CSC_CHAN_RESET;
        end else if (commit && index == `CSC_IDX_CHAN1 + k) begin
          channel_settings_reg[k] <= wdata;
        end
      end

      csc_channel_decode u_decode (
        .clk(clk),
        .reset(reset),
        .settings(channel_settings_reg[k]),
        .bias_measure_enable(bias_measure_enable_reg),
        .channel_power_off(channel_power_off[k]),
        .gain_code(gain_code[3*k+2:3*k]),
        .gain_valid(gain_valid[k]),
        .shared_reference_switch(shared_reference_switch[k]),
        .sel_electrode(sel_electrode[k]),
        .sel_shorted(sel_shorted[k]),
        .sel_bias_measure(sel_bias_measure[k]),
        .sel_supply_monitor(sel_supply_monitor[k]),
        .sel_temperature(sel_temperature[k]),
        .sel_test_signal(sel_test_signal[k]),
        .drive_on_positive_electrode(drive_on_positive_electrode[k]),
        .drive_on_negative_electrode(drive_on_negative_electrode[k])
      );
    end
  endgenerate

  // sense masks and bias measure enable
  always @(posedge clk) begin
    if (reset) begin
      bias_positive_select_reg <= `CSC_MASK_RESET;
      bias_negative_select_reg <= `CSC_MASK_RESET;
      electrode_off_positive_select_reg <= `CSC_MASK_RESET;
      electrode_off_negative_select_reg <= `CSC_MASK_RESET;
      bias_measure_enable_reg <= 1'b0;
    end else if (commit) begin
      case (index)
        `CSC_IDX_BIAS_CTRL: bias_measure_enable_reg <= wdata[`CSC_BIAS_MEASURE_ENABLE_BIT];
        `CSC_IDX_BIAS_POS: bias_positive_select_reg <= wdata;
        `CSC_IDX_BIAS_NEG: bias_negative_select_reg <= wdata;
        `CSC_IDX_EOFF_POS: electrode_off_positive_select_reg <= wdata;
        `CSC_IDX_EOFF_NEG: electrode_off_negative_select_reg <= wdata;
        default: bias_measure_enable_reg <= bias_measure_enable_reg;
      endcase
    end
  end

  // mask outputs follow their registers one cycle later
  always @(posedge clk) begin
    if (reset) begin
      bias_pos_channel_bit <= `CSC_MASK_RESET;
      bias_neg_channel_bit <= `CSC_MASK_RESET;
      electrode_off_pos_channel_bit <= `CSC_MASK_RESET;
      electrode_off_neg_channel_bit <= `CSC_MASK_RESET;
      bias_measure_enable <= 1'b0;
    end else begin
      bias_pos_channel_bit <= bias_positive_select_reg;
      bias_neg_channel_bit <= bias_negative_select_reg;
      electrode_off_pos_channel_bit <= electrode_off_positive_select_reg;
      electrode_off_neg_channel_bit <= electrode_off_negative_select_reg;
      bias_measure_enable <= bias_measure_enable_reg;
    end
  end

  // comparator results are asynchronous to clk; status is not masked, software ignores unmasked bits
  csc_status_sync u_sync_pos (
    .clk(clk),
    .reset(reset),
    .detached_async(electrode_off_pos_detached),
    .status(electrode_off_positive_status)
  );

  csc_status_sync u_sync_neg (
    .clk(clk),
    .reset(reset),
    .detached_async(electrode_off_neg_detached),
    .status(electrode_off_negative_status)
  );
endmodule // csc_config_bank

/* File: csc_config_bank_chk.sv */
// concurrent checks on the ports of the channel and sense configuration bank
`timescale 1ns/1ps
module csc_config_bank_chk (
  input wire clk,
  input wire reset,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [7:0] channel_power_off,
  input wire [23:0] gain_code,
  input wire [7:0] gain_valid,
  input wire [7:0] sel_bias_measure,
  input wire [7:0] bias_pos_channel_bit,
  input wire [7:0] electrode_off_neg_channel_bit,
  input wire bias_measure_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // a write that commits on this edge
  wire cw = avs_write && !avs_waitrequest && avs_byteenable[0];
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_rdata_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_gain_follow: assert property (cw && avs_address[7:2] == 6'h05 |-> ##2 gain_code[2:0] == $past(avs_writedata[6:4], 2))
    else $error("channel 1 gain output does not follow write");
  a_power_follow: assert property (cw && avs_address[7:2] == 6'h0c |-> ##2 channel_power_off[7] == $past(avs_writedata[7], 2))
    else $error("channel 8 power output does not follow write");
  a_bias_mask: assert property (cw && avs_address[7:2] == 6'h0d |-> ##2 bias_pos_channel_bit == $past(avs_writedata[7:0], 2))
    else $error("positive bias mask output does not follow write");
  a_eoff_mask: assert property (cw && avs_address[7:2] == 6'h10 |-> ##2 electrode_off_neg_channel_bit == $past(avs_writedata[7:0], 2))
    else $error("negative electrode-off mask output does not follow write");
  a_meas_gate: assert property (sel_bias_measure != 8'h00 |-> bias_measure_enable)
    else $error("bias measure path open without enable");
  a_gain_valid: assert property (gain_valid[0] == (gain_code[2:0] != 3'h7))
    else $error("gain valid flag wrong for channel 1");
endmodule // csc_config_bank_chk

bind csc_config_bank csc_config_bank_chk i_chk (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .channel_power_off, .gain_code, .gain_valid, .sel_bias_measure,
  .bias_pos_channel_bit, .electrode_off_neg_channel_bit, .bias_measure_enable);

/* File: tb_top.sv */
// self-checking bench for the channel and sense configuration bank
`timescale 1ns/1ps
module tb_top;
  logic clk, reset, avs_read, avs_write, avs_waitrequest, bias_measure_enable;
  logic [7:0] avs_address, electrode_off_pos_detached, electrode_off_neg_detached;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [23:0] gain_code;
  logic [7:0] channel_power_off, gain_valid, shared_reference_switch, sel_electrode, sel_shorted, sel_bias_measure;
  logic [7:0] sel_supply_monitor, sel_temperature, sel_test_signal, drive_on_positive_electrode;
  logic [7:0] drive_on_negative_electrode, bias_pos_channel_bit, bias_neg_channel_bit;
  logic [7:0] electrode_off_pos_channel_bit, electrode_off_neg_channel_bit;
  logic [7:0] m [0:19];
  int err_count = 0;
  int checked = 0;
  csc_config_bank i_dut (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .electrode_off_pos_detached, .electrode_off_neg_detached, .channel_power_off,
    .gain_code, .gain_valid, .shared_reference_switch, .sel_electrode, .sel_shorted, .sel_bias_measure,
    .sel_supply_monitor, .sel_temperature, .sel_test_signal, .drive_on_positive_electrode,
    .drive_on_negative_electrode, .bias_pos_channel_bit, .bias_neg_channel_bit, .electrode_off_pos_channel_bit,
    .electrode_off_neg_channel_bit, .bias_measure_enable);
  always #12.5 clk = ~clk;
  task close_out;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be, output logic [7:0] q);
    int n;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'($urandom), d};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_count++;
      close_out;
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function logic [13:0] dec(input logic [7:0] c, input logic en);
    logic [2:0] s;
    s = c[2:0];
    return {c[7:3], s == 3'h0, s == 3'h1, s == 3'h2 && en, s == 3'h3, s == 3'h4, s == 3'h5, s == 3'h6, s == 3'h7,
      c[6:4] != 3'h7};
  endfunction
  task check_all;
    for (int k = 0; k < 8; k++)
      chk("chan", {channel_power_off[k], gain_code[3*k+:3], shared_reference_switch[k], sel_electrode[k],
        sel_shorted[k], sel_bias_measure[k], sel_supply_monitor[k], sel_temperature[k], sel_test_signal[k],
        drive_on_positive_electrode[k], drive_on_negative_electrode[k], gain_valid[k]}, dec(m[5+k], m[3][4]));
    chk("mask", {bias_pos_channel_bit, bias_neg_channel_bit, electrode_off_pos_channel_bit,
      electrode_off_neg_channel_bit, bias_measure_enable}, {m[13], m[14], m[15], m[16], m[3][4]});
  endtask
  initial begin
    int i;
    logic [7:0] d, q;
    logic [3:0] be;
    clk = 0;
    reset = 1;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    electrode_off_pos_detached = 8'h00;
    electrode_off_neg_detached = 8'h00;
    void'($urandom(32'h622d424b));
    for (i = 0; i < 20; i++)
      m[i] = (i >= 5 && i <= 12) ? 8'h60 : 8'h00;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check_all;
    for (i = 0; i < 20; i++) begin
      bus(1'b0, 8'(4*i), 8'h00, 4'h0, q);
      chk("reset read", q, m[i]);
    end
    bus(1'b1, 8'h0c, 8'hff, 4'h1, q);
    m[3] = 8'h10;
    // every selector and gain code, one channel each
    for (i = 0; i < 8; i++) begin
      d = {i[0], i[2:0], i[1], i[2:0]};
      bus(1'b1, 8'(20+4*i), d, 4'h1, q);
      m[5+i] = d;
    end
    repeat (2) @(posedge clk);
    check_all;
    repeat (120) begin
      i = $urandom_range(17, 3);
      d = 8'($urandom);
      be = 4'($urandom);
      bus(1'b1, 8'(4*i), d, be, q);
      if (be[0] && i != 4 && i < 17)
        m[i] = (i == 3) ? (d & 8'h10) : d;
      i = $urandom_range(17, 3);
      bus(1'b0, 8'(4*i), 8'h00, 4'h0, q);
      chk("read back", q, m[i]);
    end
    repeat (2) @(posedge clk);
    check_all;
    electrode_off_pos_detached <= 8'($urandom);
    electrode_off_neg_detached <= 8'($urandom);
    repeat (4) @(posedge clk);
    bus(1'b1, 8'h48, 8'hff, 4'hf, q);
    bus(1'b0, 8'h48, 8'h00, 4'h0, q);
    chk("pos status", q, electrode_off_pos_detached);
    chk("pos status sensed", q & m[15], electrode_off_pos_detached & m[15]);
    bus(1'b0, 8'h4c, 8'h00, 4'h0, q);
    chk("neg status", q, electrode_off_neg_detached);
    chk("neg status sensed", q & m[16], electrode_off_neg_detached & m[16]);
    close_out;
  end
endmodule // tb_top
